// >>> include/tla_pkg.sv
/*
 * Shared constants and types for the telemetry limit alert logic: command
 * codes, enable bit positions, reset values, warm-up timing and carriers.
 * Assumes a 100 MHz core clock and an SMBus slave front end that turns
 * host transactions into single-cycle command strobes.
 */
package tla_pkg;

    // Command codes of the alert registers.
    localparam logic [7:0] TLA_CODE_NTC_UPPER = 8'h0b;
    localparam logic [7:0] TLA_CODE_NTC_LOWER = 8'h0c;
    localparam logic [7:0] TLA_CODE_ENABLE = 8'h0d;
    localparam logic [7:0] TLA_CODE_FLAGS = 8'h40;

    // Reset values.
    localparam logic [15:0] TLA_RST_NTC_UPPER = 16'h0000;
    localparam logic [15:0] TLA_RST_NTC_LOWER = 16'h0000;
    localparam logic [15:0] TLA_RST_ENABLE = 16'h0000;
    localparam logic [15:0] TLA_RST_FLAGS = 16'h0000;

    // Implemented bits of the enable and flag registers; 13 and 12 are reserved.
    localparam logic [15:0] TLA_BIT_MASK = 16'hcfff;

    // Bit positions shared by the enable and flag registers.
    localparam int TLA_BIT_TELEM_VALID = 15;
    localparam int TLA_BIT_BSR_DONE = 14;
    localparam int TLA_BIT_BAT_UV = 11;
    localparam int TLA_BIT_BAT_OV = 10;
    localparam int TLA_BIT_IN_UV = 9;
    localparam int TLA_BIT_IN_OV = 8;
    localparam int TLA_BIT_OUT_UV = 7;
    localparam int TLA_BIT_OUT_OV = 6;
    localparam int TLA_BIT_IIN_HI = 5;
    localparam int TLA_BIT_IBAT_LO = 4;
    localparam int TLA_BIT_DIE_HI = 3;
    localparam int TLA_BIT_BSR_HI = 2;
    localparam int TLA_BIT_NTC_HIGH = 1;
    localparam int TLA_BIT_NTC_LOW = 0;
    localparam int TLA_EXT_LO = TLA_BIT_BSR_HI;
    localparam int TLA_EXT_HI = TLA_BIT_BAT_UV;

    // Timing.
    localparam int TLA_CLK_HZ = 100_000_000;
    localparam int TLA_WARMUP_MS = 12;
    localparam int TLA_WARMUP_CYCLES = TLA_WARMUP_MS * (TLA_CLK_HZ / 1000);

    // One register command from the SMBus front end.
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] code;
        logic [15:0] wdata;
    } tla_cmd_t;

    // Warm-up timer states.
    typedef enum logic [2:0] {
        TLA_WU_IDLE = 3'b001,
        TLA_WU_WARM = 3'b010,
        TLA_WU_VALID = 3'b100
    } tla_wu_state_t;

endpackage : tla_pkg

// >>> hw/tla_warmup_timer.sv
/*
 * Telemetry warm-up timer: reports valid readings only after the measurement
 * system has run continuously for the warm-up interval.
 * Assumes telemetry_on is synchronous to clk and stays high while running.
 */
`timescale 1ns/10ps
module tla_warmup_timer
    import tla_pkg::*;
#(
    parameter int WARMUP_CYCLES = TLA_WARMUP_CYCLES
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Measurement system
    input wire logic telemetry_on,
    output logic telemetry_valid
);

    localparam int CNT_W = $clog2(WARMUP_CYCLES + 1);
    localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(WARMUP_CYCLES - 1);

    tla_wu_state_t state;
    logic [CNT_W-1:0] count;

    // Dropping telemetry_on at any point restarts the full interval.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state <= TLA_WU_IDLE;
        end else begin
            case (state)
                TLA_WU_IDLE: begin
                    if (telemetry_on) begin
                        state <= TLA_WU_WARM;
                    end
                end
                TLA_WU_WARM: begin
                    if (!telemetry_on) begin
                        state <= TLA_WU_IDLE;
                    end else if (count == CNT_LAST) begin
                        state <= TLA_WU_VALID; // see (RULE7)
                    end
                end
                TLA_WU_VALID: begin
                    if (!telemetry_on) begin
                        state <= TLA_WU_IDLE;
                    end
                end
                default: begin
                    state <= TLA_WU_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            count <= '0;
        end else if (state == TLA_WU_WARM) begin
            count <= count + CNT_W'(1);
        end else begin
            count <= '0;
        end
    end

    assign telemetry_valid = (state == TLA_WU_VALID);

endmodule : tla_warmup_timer

// >>> hw/tla_alert_logic.sv
/*
 * Telemetry limit alert logic: thermistor thresholds, limit alert enables,
 * sticky alert flags, the shared SMBALERT pin and the charger start gate.
 * Assumes an SMBus slave front end delivers one-cycle command strobes and
 * that the other limit comparators deliver their results as levels.
 */
// What this block does
// (RULE1) Writable signed thermistor upper threshold at code 0x0b, reset zero.
// (RULE2) Writable signed thermistor lower threshold at code 0x0c, reset zero.
// (RULE3) Reading above upper threshold with enable set latches the high flag.
// (RULE4) Reading below lower threshold with enable set latches the low flag.
// (RULE5) Sixteen-bit enable register at code 0x0d, reset zero, gates alert sources.
// (RULE6) Enable bit 15 flags and alerts when telemetry becomes valid.
// (RULE7) Telemetry counts as invalid for 12 ms after the measurement system starts.
// (RULE8) Charger stays disabled until warm-up ends, whatever bit 15 holds.
// (RULE9) Enable bit 14 flags and alerts when a resistance measurement finishes.
// (RULE10) Enable bit 11 flags and alerts on battery voltage below floor.
// (RULE11) Enable bit 10 flags and alerts on battery voltage above ceiling.
// (RULE12) Enable bit 9 flags and alerts on input voltage below floor.
// (RULE13) Enable bit 8 flags and alerts on input voltage above ceiling.
// (RULE14) Enable bit 7 flags and alerts on output voltage below floor.
// (RULE15) Enable bit 6 flags and alerts on output voltage above ceiling.
// (RULE16) Bit 1 enables thermistor high alert, bit 0 thermistor low alert.
// (RULE17) Bits 5..2 gate input current, battery current, die temperature, resistance.
// (RULE18) SMBALERT holds while any enabled flag is latched, until all are cleared.
// (RULE19) Enable bits 13 and 12 are reserved, read zero, ignore writes.
`timescale 1ns/10ps
module tla_alert_logic
    import tla_pkg::*;
#(
    parameter int WARMUP_CYCLES = TLA_WARMUP_CYCLES
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Register commands from the SMBus front end
    input wire tla_cmd_t cmd,
    output logic [15:0] rdata,
    output logic rdata_valid,
    // Measurement system
    input wire logic telemetry_on,
    input wire logic signed [15:0] ntc_reading,
    input wire logic [TLA_EXT_HI:TLA_EXT_LO] limit_hit,
    input wire logic bsr_done,
    output logic telemetry_valid,
    // Charger control
    input wire logic charger_request,
    output logic charger_enable,
    // SMBALERT open-drain pin, driven low while oe is high
    input wire logic smbalert_in,
    output logic smbalert_out,
    output logic smbalert_oe
);

    logic [15:0] ntc_upper;
    logic [15:0] ntc_lower;
    logic [15:0] enable;
    logic [15:0] flags;
    logic [15:0] flag_set;
    logic [15:0] flag_clr;
    logic [15:0] pending;
    logic valid_d;
    logic valid_rise;
    logic ntc_high_hit;
    logic ntc_low_hit;
    logic wr_upper;
    logic wr_lower;
    logic wr_enable;
    logic wr_flags;

    // Shared by the write strobes and the read mux.
    function automatic logic code_is(input logic [7:0] code, input logic [7:0] target);
        code_is = (code == target);
    endfunction : code_is

    assign wr_upper = cmd.wr && code_is(cmd.code, TLA_CODE_NTC_UPPER);
    assign wr_lower = cmd.wr && code_is(cmd.code, TLA_CODE_NTC_LOWER);
    assign wr_enable = cmd.wr && code_is(cmd.code, TLA_CODE_ENABLE);
    assign wr_flags = cmd.wr && code_is(cmd.code, TLA_CODE_FLAGS);

    tla_warmup_timer #(
        .WARMUP_CYCLES(WARMUP_CYCLES)
    ) u_warmup (
        .clk(clk),
        .rst(rst),
        .telemetry_on(telemetry_on),
        .telemetry_valid(telemetry_valid)
    );

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ntc_upper <= TLA_RST_NTC_UPPER;
        end else if (wr_upper) begin
            ntc_upper <= cmd.wdata; // see (RULE1)
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ntc_lower <= TLA_RST_NTC_LOWER;
        end else if (wr_lower) begin
            ntc_lower <= cmd.wdata; // see (RULE2)
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            enable <= TLA_RST_ENABLE;
        end else if (wr_enable) begin
            enable <= cmd.wdata & TLA_BIT_MASK; // see (RULE5) see (RULE19)
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            valid_d <= 1'b0;
        end else begin
            valid_d <= telemetry_valid;
        end
    end

    assign valid_rise = telemetry_valid && !valid_d;

    // Readings taken before warm-up are inaccurate, so no limit is judged then.
    assign ntc_high_hit = telemetry_valid && (ntc_reading > $signed(ntc_upper)); // see (RULE3)
    assign ntc_low_hit = telemetry_valid && (ntc_reading < $signed(ntc_lower)); // see (RULE4)

    always_comb begin
        flag_set = '0;
        flag_set[TLA_BIT_TELEM_VALID] = valid_rise && enable[TLA_BIT_TELEM_VALID]; // see (RULE6)
        flag_set[TLA_BIT_BSR_DONE] = bsr_done && enable[TLA_BIT_BSR_DONE]; // see (RULE9)
        // see (RULE10) see (RULE11) see (RULE12) see (RULE13) see (RULE14) see (RULE15)
        // see (RULE17)
        flag_set[TLA_EXT_HI:TLA_EXT_LO] = limit_hit & enable[TLA_EXT_HI:TLA_EXT_LO]
            & {(TLA_EXT_HI - TLA_EXT_LO + 1){telemetry_valid}};
        flag_set[TLA_BIT_NTC_HIGH] = ntc_high_hit && enable[TLA_BIT_NTC_HIGH]; // see (RULE16)
        flag_set[TLA_BIT_NTC_LOW] = ntc_low_hit && enable[TLA_BIT_NTC_LOW]; // see (RULE16)
    end

    // Writing zero to a flag bit clears it; writing one leaves it alone.
    assign flag_clr = wr_flags ? ~cmd.wdata : 16'h0000;

    // A condition arriving in the clearing cycle wins, so no event is lost.
    genvar gi;
    generate
        for (gi = 0; gi < 16; gi++) begin : g_flag
            if (TLA_BIT_MASK[gi]) begin : g_impl
                always_ff @(posedge clk or posedge rst) begin
                    if (rst) begin
                        flags[gi] <= TLA_RST_FLAGS[gi];
                    end else begin
                        flags[gi] <= flag_set[gi] || (flags[gi] && !flag_clr[gi]); // see (RULE3)
                    end
                end
            end else begin : g_rsvd
                assign flags[gi] = 1'b0; // see (RULE19)
            end
        end
    endgenerate

    assign pending = flags & enable;

    // The pin is only ever pulled low; the bus pull-up releases it.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            smbalert_oe <= 1'b0;
        end else begin
            smbalert_oe <= |pending; // see (RULE18)
        end
    end

    assign smbalert_out = 1'b0;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            charger_enable <= 1'b0;
        end else begin
            charger_enable <= charger_request && telemetry_valid; // see (RULE8)
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata <= 16'h0000;
        end else if (cmd.rd) begin
            if (code_is(cmd.code, TLA_CODE_NTC_UPPER)) begin
                rdata <= ntc_upper;
            end else if (code_is(cmd.code, TLA_CODE_NTC_LOWER)) begin
                rdata <= ntc_lower;
            end else if (code_is(cmd.code, TLA_CODE_ENABLE)) begin
                rdata <= enable;
            end else if (code_is(cmd.code, TLA_CODE_FLAGS)) begin
                rdata <= flags;
            end else begin
                rdata <= 16'h0000;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata_valid <= 1'b0;
        end else begin
            rdata_valid <= cmd.rd;
        end
    end

    // Helper logic for the assertions below.
    logic [31:0] on_cycles;
    logic pin_seen_low;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            on_cycles <= 32'h0000_0000;
        end else if (!telemetry_on) begin
            on_cycles <= 32'h0000_0000;
        end else if (on_cycles != 32'hffff_ffff) begin
            on_cycles <= on_cycles + 32'h0000_0001;
        end
    end

    // Tracks the level seen on the shared wire while this device pulls it.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pin_seen_low <= 1'b0;
        end else begin
            pin_seen_low <= smbalert_oe && !smbalert_in;
        end
    end

    sequence s_flag_pending;
        |(flags & enable);
    endsequence

    sequence s_all_clear;
        (flags & enable) == 16'h0000;
    endsequence

    a_upper_write: assert property (@(posedge clk) disable iff (rst) // see (RULE1)
        wr_upper |=> ntc_upper == $past(cmd.wdata))
        else $error("upper threshold did not take written value");

    a_lower_write: assert property (@(posedge clk) disable iff (rst) // see (RULE2)
        wr_lower |=> ntc_lower == $past(cmd.wdata))
        else $error("lower threshold did not take written value");

    a_ntc_high_set: assert property (@(posedge clk) disable iff (rst) // see (RULE3)
        (telemetry_valid && enable[TLA_BIT_NTC_HIGH] && ntc_reading > $signed(ntc_upper))
        |=> flags[TLA_BIT_NTC_HIGH])
        else $error("high thermistor flag missed");

    a_ntc_low_set: assert property (@(posedge clk) disable iff (rst) // see (RULE4)
        (telemetry_valid && enable[TLA_BIT_NTC_LOW] && ntc_reading < $signed(ntc_lower))
        |=> flags[TLA_BIT_NTC_LOW])
        else $error("low thermistor flag missed");

    a_enable_write: assert property (@(posedge clk) disable iff (rst) // see (RULE5)
        wr_enable |=> enable == ($past(cmd.wdata) & TLA_BIT_MASK))
        else $error("enable register write mismatch");

    a_valid_alert: assert property (@(posedge clk) disable iff (rst) // see (RULE6)
        ($rose(telemetry_valid) && enable[TLA_BIT_TELEM_VALID])
        |=> flags[TLA_BIT_TELEM_VALID] ##1 smbalert_oe)
        else $error("telemetry valid alert missed");

    a_warmup_length: assert property (@(posedge clk) disable iff (rst) // see (RULE7)
        telemetry_valid |-> on_cycles >= 32'(WARMUP_CYCLES))
        else $error("telemetry valid before warm-up ended");

    a_charger_gate: assert property (@(posedge clk) disable iff (rst) // see (RULE8)
        charger_enable |-> $past(telemetry_valid) && $past(charger_request))
        else $error("charger enabled before warm-up ended");

    a_bsr_done_set: assert property (@(posedge clk) disable iff (rst) // see (RULE9)
        (bsr_done && enable[TLA_BIT_BSR_DONE]) |=> flags[TLA_BIT_BSR_DONE])
        else $error("resistance done flag missed");

    generate
        for (gi = TLA_EXT_LO; gi <= TLA_EXT_HI; gi++) begin : g_ext_chk
            a_limit_flag_set: assert property (@(posedge clk) disable iff (rst) // see (RULE10)
                (telemetry_valid && limit_hit[gi] && enable[gi]) |=> flags[gi])
                else $error("limit flag missed");
        end
    endgenerate

    a_alert_raise: assert property (@(posedge clk) disable iff (rst) // see (RULE18)
        s_flag_pending |=> smbalert_oe)
        else $error("alert not raised for pending flag");

    a_alert_release: assert property (@(posedge clk) disable iff (rst) // see (RULE18)
        s_all_clear |=> !smbalert_oe)
        else $error("alert held with no pending flag");

    a_reserved_zero: assert property (@(posedge clk) disable iff (rst) // see (RULE19)
        enable[13:12] == 2'b00 && flags[13:12] == 2'b00)
        else $error("reserved bits not zero");

    a_set_beats_clear: assert property (@(posedge clk) disable iff (rst) // see (RULE3)
        (flag_set[TLA_BIT_NTC_HIGH] && flag_clr[TLA_BIT_NTC_HIGH]) |=> flags[TLA_BIT_NTC_HIGH])
        else $error("set lost against clear");

    a_pin_follows: assert property (@(posedge clk) disable iff (rst) // see (RULE18)
        pin_seen_low |-> $past(smbalert_oe))
        else $error("pin low seen without drive");

endmodule : tla_alert_logic

// >>> test/tla_host_model.sv
/*
 * Host SMBus controller model: issues register commands to the alert logic
 * and resolves the open-drain SMBALERT wire with its pull-up.
 * Assumes the device answers a read one cycle after the taken strobe.
 */
`timescale 1ns/10ps
module tla_host_model
    import tla_pkg::*;
(
    // Clock
    input wire logic clk,
    // Register port
    output tla_cmd_t cmd,
    input wire logic [15:0] rdata,
    input wire logic rdata_valid,
    // SMBALERT wire
    input wire logic smbalert_out,
    input wire logic smbalert_oe,
    output logic smbalert_in
);
    // Nobody pulling means the pull-up wins.
    assign smbalert_in = smbalert_oe ? smbalert_out : 1'b1;

    initial begin
        cmd = '0;
    end

    // Qualifiers are cleared and the code is inverted on release so a stale code is never mistaken for a live one.
    task automatic write_reg(input logic [7:0] code, input logic [15:0] data);
        @(posedge clk);
        cmd <= '{wr: 1'b1, rd: 1'b0, code: code, wdata: data};
        @(posedge clk);
        cmd <= '{wr: 1'b0, rd: 1'b0, code: ~code, wdata: ~data};
    endtask : write_reg

    task automatic read_reg(input logic [7:0] code, output logic [15:0] data,
                            output logic ok);
        @(posedge clk);
        cmd <= '{wr: 1'b0, rd: 1'b1, code: code, wdata: 16'h0000};
        @(posedge clk);
        cmd <= '{wr: 1'b0, rd: 1'b0, code: ~code, wdata: 16'hffff};
        @(posedge clk);
        ok = rdata_valid;
        data = rdata;
    endtask : read_reg

    // Writing zero to a flag bit clears it, a one keeps it.
    task automatic clear_flags(input logic [15:0] keep);
        write_reg(TLA_CODE_FLAGS, keep);
    endtask : clear_flags

endmodule : tla_host_model

// >>> test/test_telemetry_limit_alert_logic.sv
/*
 * Self-checking testbench for the telemetry limit alert logic.
 * Assumes a shortened warm-up of 20 cycles and a host model that owns the
 * register port and the SMBALERT wire.
 */
`timescale 1ns/10ps
module test_telemetry_limit_alert_logic
    import tla_pkg::*;
;
    localparam int WU = 20;
    logic clk;
    logic rst;
    tla_cmd_t cmd;
    logic [15:0] rdata;
    logic rdata_valid;
    logic telemetry_on;
    logic signed [15:0] ntc_reading;
    logic [TLA_EXT_HI:TLA_EXT_LO] limit_hit;
    logic bsr_done;
    logic telemetry_valid;
    logic charger_request;
    logic charger_enable;
    logic smbalert_in;
    logic smbalert_out;
    logic smbalert_oe;
    int err_count = 0;
    int check_count = 0;

    tla_alert_logic #(.WARMUP_CYCLES(WU)) i_tla_alert_logic (
        .clk(clk), .rst(rst), .cmd(cmd), .rdata(rdata), .rdata_valid(rdata_valid),
        .telemetry_on(telemetry_on), .ntc_reading(ntc_reading), .limit_hit(limit_hit),
        .bsr_done(bsr_done), .telemetry_valid(telemetry_valid),
        .charger_request(charger_request), .charger_enable(charger_enable),
        .smbalert_in(smbalert_in), .smbalert_out(smbalert_out), .smbalert_oe(smbalert_oe)
    );

    tla_host_model i_tla_host_model (
        .clk(clk), .cmd(cmd), .rdata(rdata), .rdata_valid(rdata_valid),
        .smbalert_out(smbalert_out), .smbalert_oe(smbalert_oe), .smbalert_in(smbalert_in)
    );

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic check_word(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check_word

    task automatic check_bit(input logic got, input logic exp);
        check_word({15'h0000, got}, {15'h0000, exp});
    endtask : check_bit

    task automatic rd_check(input logic [7:0] code, input logic [15:0] exp);
        logic [15:0] d;
        logic ok;
        i_tla_host_model.read_reg(code, d, ok);
        check_bit(ok, 1'b1);
        check_word(d, exp);
    endtask : rd_check

    task automatic wr(input logic [7:0] code, input logic [15:0] data);
        i_tla_host_model.write_reg(code, data);
    endtask : wr

    // One-cycle condition, then two edges so the alert pin has settled.
    task automatic hit(input logic [TLA_EXT_HI:TLA_EXT_LO] v, input logic b);
        @(posedge clk);
        limit_hit <= v;
        bsr_done <= b;
        @(posedge clk);
        limit_hit <= '0;
        bsr_done <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
    endtask : hit

    task automatic clear_and_settle(input logic [15:0] keep, input logic pin);
        i_tla_host_model.clear_flags(keep);
        repeat (2) @(posedge clk);
        #1 check_bit(smbalert_in, pin);
    endtask : clear_and_settle

    task automatic test_done();
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : test_done

    task automatic test_reset();
        rd_check(TLA_CODE_NTC_UPPER, 16'h0000);
        rd_check(TLA_CODE_NTC_LOWER, 16'h0000);
        rd_check(TLA_CODE_ENABLE, 16'h0000);
        rd_check(TLA_CODE_FLAGS, 16'h0000);
        $display("test_reset done");
    endtask : test_reset

    task automatic test_regs();
        wr(TLA_CODE_NTC_UPPER, 16'h8000);
        wr(TLA_CODE_NTC_LOWER, 16'h7fff);
        wr(TLA_CODE_ENABLE, 16'hffff);
        wr(8'h22, 16'h1234);
        rd_check(TLA_CODE_NTC_UPPER, 16'h8000);
        rd_check(TLA_CODE_NTC_LOWER, 16'h7fff);
        rd_check(TLA_CODE_ENABLE, 16'hcfff);
        rd_check(8'h22, 16'h0000);
        wr(TLA_CODE_ENABLE, 16'h8000);
        $display("test_regs done");
    endtask : test_regs

    task automatic test_warmup();
        @(posedge clk);
        telemetry_on <= 1'b1;
        charger_request <= 1'b1;
        repeat (WU) @(posedge clk);
        #1 check_bit(telemetry_valid, 1'b0);
        check_bit(charger_enable, 1'b0);
        @(posedge clk);
        #1 check_bit(telemetry_valid, 1'b1);
        repeat (2) @(posedge clk);
        #1 check_bit(charger_enable, 1'b1);
        check_bit(smbalert_in, 1'b0);
        rd_check(TLA_CODE_FLAGS, 16'h8000);
        clear_and_settle(16'h0000, 1'b1);
        $display("test_warmup done");
    endtask : test_warmup

    task automatic test_limits();
        logic [15:0] bitv;
        for (int i = TLA_EXT_LO; i <= TLA_EXT_HI; i++) begin
            bitv = 16'h0001 << i;
            wr(TLA_CODE_ENABLE, bitv);
            hit('1, 1'b0);
            check_bit(smbalert_in, 1'b0);
            rd_check(TLA_CODE_FLAGS, bitv);
            clear_and_settle(16'h0000, 1'b1);
        end
        $display("test_limits done");
    endtask : test_limits

    task automatic test_ntc();
        wr(TLA_CODE_NTC_UPPER, 16'h0064);
        wr(TLA_CODE_NTC_LOWER, 16'hfffb);
        wr(TLA_CODE_ENABLE, 16'h0003);
        ntc_reading <= 16'h0064;
        repeat (3) @(posedge clk);
        rd_check(TLA_CODE_FLAGS, 16'h0000);
        ntc_reading <= 16'h0065;
        repeat (3) @(posedge clk);
        rd_check(TLA_CODE_FLAGS, 16'h0002);
        // The reading is still above the ceiling, so the clear must lose to the set.
        clear_and_settle(16'h0000, 1'b0);
        rd_check(TLA_CODE_FLAGS, 16'h0002);
        ntc_reading <= 16'h0000;
        clear_and_settle(16'h0000, 1'b1);
        @(posedge clk);
        ntc_reading <= 16'hfffa;
        repeat (3) @(posedge clk);
        #1 check_bit(smbalert_in, 1'b0);
        rd_check(TLA_CODE_FLAGS, 16'h0001);
        ntc_reading <= 16'h0000;
        clear_and_settle(16'h0000, 1'b1);
        $display("test_ntc done");
    endtask : test_ntc

    task automatic test_bsr();
        wr(TLA_CODE_ENABLE, 16'h0000);
        hit('0, 1'b1);
        rd_check(TLA_CODE_FLAGS, 16'h0000);
        wr(TLA_CODE_ENABLE, 16'h4000);
        hit('0, 1'b1);
        check_bit(smbalert_in, 1'b0);
        rd_check(TLA_CODE_FLAGS, 16'h4000);
        clear_and_settle(16'h0000, 1'b1);
        $display("test_bsr done");
    endtask : test_bsr

    task automatic test_multi();
        wr(TLA_CODE_ENABLE, 16'h0c00);
        hit(10'h300, 1'b0);
        rd_check(TLA_CODE_FLAGS, 16'h0c00);
        clear_and_settle(16'h0800, 1'b0);
        rd_check(TLA_CODE_FLAGS, 16'h0800);
        clear_and_settle(16'h0000, 1'b1);
        $display("test_multi done");
    endtask : test_multi

    initial begin
        rst = 1'b1;
        telemetry_on = 1'b0;
        ntc_reading = 16'h0000;
        limit_hit = '0;
        bsr_done = 1'b0;
        charger_request = 1'b0;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        test_reset();
        test_regs();
        test_warmup();
        test_limits();
        test_ntc();
        test_bsr();
        test_multi();
        test_done();
    end

    // The whole sequence needs well under two thousand cycles.
    initial begin
        repeat (20000) @(posedge clk);
        err_count++;
        test_done();
    end

endmodule : test_telemetry_limit_alert_logic
